// file: include/can_object_send_request_defines.vh
`ifndef CAN_OBJECT_SEND_REQUEST_DEFINES_VH
`define CAN_OBJECT_SEND_REQUEST_DEFINES_VH

// register indices on the plain port
`define REG_OBJECT_SEND_REQUEST_LOW      4'h0
`define REG_OBJECT_SEND_REQUEST_HIGH     4'h1
`define REG_FIFO_DIR       4'h2
`define REG_FIFO_SEL       4'h3
`define REG_FIFO_PTR_LOW   4'h4
`define REG_FIFO_PTR_HIGH  4'h5
`define REG_FIFO_LEVEL     4'h6
`define REG_OPMODE         4'h7

// field position, counts and width
`define QUEUE_BIT          0
`define OBJ_COUNT          8
`define FIFO_COUNT         7
`define PTR_WIDTH          32

// reset values
`define OBJECT_SEND_REQUEST_RESET        8'h00
`define DIR_RESET          8'h00
`define PTR_RESET          32'h0000_0000

// message slot spacing in bytes, and transmit time
`define SLOT_BYTES         32'h0000_0010
`define SEND_CYCLES        8'h10

`define FIFO_DEPTH         8
`define FIFO_AW            3

`endif

// file: design/send_fifo.v
module send_fifo #(
    parameter WIDTH = 3,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_sys,   // system clock
    input  wire             rst_n,     // sync reset, active low
    input  wire [WIDTH-1:0] inData,    // word written
    input  wire             inValid,   // write request
    output wire             inReady,   // not full
    output reg  [WIDTH-1:0] outData,   // registered head word
    output reg              outValid,  // head word present
    input  wire             outReady   // consumer takes head
);
    reg [WIDTH-1:0] memFf [0:DEPTH-1];
    reg [AW-1:0]    wrPtrFf;
    reg [AW-1:0]    rdPtrFf;
    reg [AW:0]      countFf;
    wire            doWrite;
    wire            doRead;
    wire            memHasWord;

    assign memHasWord = (countFf != {(AW+1){1'b0}});
    assign doRead     = memHasWord && (!outValid || outReady);
    assign doWrite    = inValid && inReady;
    assign inReady    = (countFf != DEPTH[AW:0]);

    always @(posedge clk_sys)
    begin
        if (doWrite)
        begin
            memFf[wrPtrFf] <= inData;
        end
    end

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            wrPtrFf  <= {AW{1'b0}};
            rdPtrFf  <= {AW{1'b0}};
            countFf  <= {(AW+1){1'b0}};
            outValid <= 1'b0;
            outData  <= {WIDTH{1'b0}};
        end
        else
        begin
            if (doWrite)
            begin
                wrPtrFf <= wrPtrFf + {{(AW-1){1'b0}}, 1'b1};
            end
            if (doRead)
            begin
                rdPtrFf  <= rdPtrFf + {{(AW-1){1'b0}}, 1'b1};
                outData  <= memFf[rdPtrFf];
                outValid <= 1'b1;
            end
            else if (outReady)
            begin
                outValid <= 1'b0;
            end
            if (doWrite && !doRead)
            begin
                countFf <= countFf + {{AW{1'b0}}, 1'b1};
            end
            else if (doRead && !doWrite)
            begin
                countFf <= countFf - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // send_fifo

// file: design/can_tx_request_and_fifo_pointer.v
// Our own choices: the strobed register port and the placing of the registers.
`include "can_object_send_request_defines.vh"

module can_tx_request_and_fifo_pointer (
    input  wire        clk_sys,       // 40 MHz clock
    input  wire        rst_n,         // sync reset, active low
    input  wire [3:0]  regAddr,       // register index
    input  wire [15:0] regWrData,     // write data
    input  wire        regWr,         // write strobe
    input  wire        regRd,         // read strobe
    output reg  [15:0] regRdData_ff,  // read data, cycle after strobe
    input  wire        msgSent,       // one message of active object sent ok
    input  wire [2:0]  fifoPush,      // fifo index taking a received message
    input  wire        fifoPushValid, // received message arrives
    input  wire [2:0]  fifoPop,       // fifo index software consumed / sent
    input  wire        fifoPopValid,  // one slot released
    output reg         txBusy_ff,     // an object is being transmitted
    output reg  [2:0]  txObject_ff,   // object now on the wire
    output reg         queueFull_ff   // request queue can take no more
);
    reg  [7:0]  objectSendRequest_ff;
    reg  [7:0]  fifoDirectionTransmit_ff;
    reg  [2:0]  fifoSel_ff;
    reg         configMode_ff;
    reg  [3:0]  pendCnt_ff [0:7];
    reg  [31:0] headPtr_ff [1:7];
    reg  [31:0] tailPtr_ff [1:7];
    reg  [7:0]  sendTimer_ff;
    reg  [7:0]  nxt_objectSendRequest;
    reg  [15:0] nxt_rdData;
    wire [2:0]  qData;
    wire        qValid;
    wire        qReady;
    wire        qInReady;
    wire [31:0] selPtr;
    wire [7:0]  setMask;
    wire [7:0]  newSet;
    reg  [7:0]  waitQ_ff;
    reg  [2:0]  newObj;
    reg         newObjValid;
    integer     i;

    // pointer per direction, no valid value for index 0
    function [31:0] userPointer;
        input [2:0] idx;
        input       isTx;
        begin
            if (idx == 3'h0)
            begin
                userPointer = `PTR_RESET;
            end
            else if (isTx)
            begin
                userPointer = headPtr_ff[idx];
            end
            else
            begin
                userPointer = tailPtr_ff[idx];
            end
        end
    endfunction

    assign selPtr = userPointer(fifoSel_ff, fifoDirectionTransmit_ff[fifoSel_ff]);

    // bit 0 always transmits; others only if their fifo transmits
    assign setMask = (regWr && regAddr == `REG_OBJECT_SEND_REQUEST_LOW) ?
                     (regWrData[7:0] & {fifoDirectionTransmit_ff[7:1], 1'b1}) : 8'h00;
    // several bits in one write wait here, pushed one per cycle
    assign newSet = qInReady ? (setMask & ~objectSendRequest_ff) : 8'h00;

    always @*
    begin
        newObj      = 3'h0;
        newObjValid = 1'b0;
        for (i = 7; i >= 0; i = i - 1)
        begin
            if (waitQ_ff[i])
            begin
                newObj      = i[2:0];
                newObjValid = 1'b1;
            end
        end
    end

    send_fifo #(
        .WIDTH (3),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_queue (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inData   (newObj),
        .inValid  (newObjValid),
        .inReady  (qInReady),
        .outData  (qData),
        .outValid (qValid),
        .outReady (qReady)
    );

    // no pop while configuring, or the request would be lost
    assign qReady = !txBusy_ff && !configMode_ff;

    // transmit engine: one object at a time, counted per message
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            txBusy_ff    <= 1'b0;
            txObject_ff  <= 3'h0;
            sendTimer_ff <= 8'h00;
        end
        else if (!txBusy_ff)
        begin
            if (qValid && !configMode_ff)
            begin
                txBusy_ff    <= 1'b1;
                txObject_ff  <= qData;
                sendTimer_ff <= `SEND_CYCLES;
            end
        end
        else if (msgSent && pendCnt_ff[txObject_ff] == 4'h1)
        begin
            txBusy_ff <= 1'b0;
        end
    end

    always @*
    begin
        nxt_objectSendRequest = objectSendRequest_ff;
        // clearing only by hardware; zeros written are not aborts
        if (txBusy_ff && msgSent && pendCnt_ff[txObject_ff] == 4'h1)
        begin
            nxt_objectSendRequest[txObject_ff] = 1'b0;
        end
        if (qInReady)
        begin
            nxt_objectSendRequest = nxt_objectSendRequest | newSet;
        end
    end

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            objectSendRequest_ff     <= `OBJECT_SEND_REQUEST_RESET;
            fifoDirectionTransmit_ff <= `DIR_RESET;
            fifoSel_ff               <= 3'h1;
            configMode_ff            <= 1'b1;
            queueFull_ff             <= 1'b0;
            waitQ_ff                 <= 8'h00;
            for (i = 0; i < 8; i = i + 1)
            begin
                pendCnt_ff[i] <= 4'h0;
            end
        end
        else
        begin
            objectSendRequest_ff <= nxt_objectSendRequest;
            queueFull_ff         <= !qInReady;
            waitQ_ff             <= (waitQ_ff & ~((newObjValid && qInReady) ?
                                    (8'h01 << newObj) : 8'h00)) | newSet;
            // pending message count per object: one per set request
            for (i = 0; i < 8; i = i + 1)
            begin
                if (newSet[i])
                begin
                    pendCnt_ff[i] <= 4'h1;
                end
                else if (txBusy_ff && msgSent && txObject_ff == i[2:0] && pendCnt_ff[i] != 4'h0)
                begin
                    pendCnt_ff[i] <= pendCnt_ff[i] - 4'h1;
                end
            end
            if (regWr)
            begin
                if (regAddr == `REG_FIFO_DIR)
                begin
                    fifoDirectionTransmit_ff <= {regWrData[7:1], 1'b0};
                end
                else if (regAddr == `REG_FIFO_SEL)
                begin
                    fifoSel_ff <= regWrData[2:0];
                end
                else if (regAddr == `REG_OPMODE)
                begin
                    configMode_ff <= regWrData[0];
                end
            end
        end
    end

    // head advances on push, tail on release, for fifos 1 to 7 outside config mode; direction picks which one is read
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            for (i = 1; i < 8; i = i + 1)
            begin
                headPtr_ff[i] <= `PTR_RESET;
                tailPtr_ff[i] <= `PTR_RESET;
            end
        end
        else if (configMode_ff)
        begin
            // pointers restart while configuring, hence unreliable reads
            for (i = 1; i < 8; i = i + 1)
            begin
                headPtr_ff[i] <= `PTR_RESET;
                tailPtr_ff[i] <= `PTR_RESET;
            end
        end
        else
        begin
            for (i = 1; i < 8; i = i + 1)
            begin
                if (fifoPushValid && fifoPush == i[2:0])
                begin
                    headPtr_ff[i] <= headPtr_ff[i] + `SLOT_BYTES;
                end
                if (fifoPopValid && fifoPop == i[2:0])
                begin
                    tailPtr_ff[i] <= tailPtr_ff[i] + `SLOT_BYTES;
                end
            end
        end
    end

    always @*
    begin
        nxt_rdData = 16'h0000;
        if (regAddr == `REG_OBJECT_SEND_REQUEST_LOW)
        begin
            nxt_rdData = {8'h00, objectSendRequest_ff};
        end
        else if (regAddr == `REG_OBJECT_SEND_REQUEST_HIGH)
        begin
            nxt_rdData = 16'h0000;
        end
        else if (regAddr == `REG_FIFO_DIR)
        begin
            nxt_rdData = {8'h00, fifoDirectionTransmit_ff};
        end
        else if (regAddr == `REG_FIFO_SEL)
        begin
            nxt_rdData = {13'h0000, fifoSel_ff};
        end
        else if (regAddr == `REG_FIFO_PTR_LOW)
        begin
            nxt_rdData = selPtr[15:0];
        end
        else if (regAddr == `REG_FIFO_PTR_HIGH)
        begin
            nxt_rdData = selPtr[31:16];
        end
        else if (regAddr == `REG_FIFO_LEVEL)
        begin
            nxt_rdData = {11'h000, queueFull_ff, txBusy_ff, txObject_ff};
        end
        else if (regAddr == `REG_OPMODE)
        begin
            nxt_rdData = {15'h0000, configMode_ff};
        end
    end

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            regRdData_ff <= 16'h0000;
        end
        else if (regRd)
        begin
            regRdData_ff <= nxt_rdData;
        end
        else
        begin
            regRdData_ff <= 16'h0000;
        end
    end
endmodule // can_tx_request_and_fifo_pointer

// file: tb/can_object_send_request_assertions.sv
module can_object_send_request_assertions (
    input wire logic        clk_sys,       // clock
    input wire logic        rst_n,         // sync reset
    input wire logic [3:0]  regAddr,       // index
    input wire logic [15:0] regWrData,     // write data
    input wire logic        regWr,         // write strobe
    input wire logic        regRd,         // read strobe
    input wire logic [15:0] regRdData_ff,  // read data
    input wire logic        msgSent,       // sent pulse
    input wire logic [2:0]  fifoPush,      // push index
    input wire logic        fifoPushValid, // push pulse
    input wire logic [2:0]  fifoPop,       // pop index
    input wire logic        fifoPopValid,  // pop pulse
    input wire logic        txBusy_ff,     // sending
    input wire logic [2:0]  txObject_ff,   // object sent
    input wire logic        queueFull_ff   // queue full
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    property p_rd_idle;
        !regRd |=> regRdData_ff == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_rd_high;
        regRd && regAddr == 4'h1 |=> regRdData_ff == 16'h0000;
    endproperty
    a_rd_high: assert property (p_rd_high) else $error("high request not zero");
    property p_rd_upper;
        regRd && regAddr == 4'h0 |=> regRdData_ff[15:8] == 8'h00;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper byte not zero");
    property p_unmapped;
        regRd && regAddr[3] |=> regRdData_ff == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
    property p_obj_hold;
        txBusy_ff && !msgSent |=> txBusy_ff && $stable(txObject_ff);
    endproperty
    a_obj_hold: assert property (p_obj_hold) else $error("send dropped early");
    property p_sent_drop;
        txBusy_ff && msgSent |=> !txBusy_ff;
    endproperty
    a_sent_drop: assert property (p_sent_drop) else $error("busy after sent");
    property p_bit_pending;
        regRd && regAddr == 4'h0 && txBusy_ff && !msgSent |=> regRdData_ff[$past(txObject_ff)];
    endproperty
    a_bit_pending: assert property (p_bit_pending) else $error("request bit lost");
    property p_no_abort;
        txBusy_ff && !msgSent && regWr && regAddr == 4'h0 |=>
            txBusy_ff ##1 (txBusy_ff || $past(msgSent));
    endproperty
    a_no_abort: assert property (p_no_abort) else $error("write aborted send");
endmodule // can_object_send_request_assertions

bind can_tx_request_and_fifo_pointer can_object_send_request_assertions can_object_send_request_assertions_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData_ff), .msgSent(msgSent),
    .fifoPush(fifoPush), .fifoPushValid(fifoPushValid), .fifoPop(fifoPop),
    .fifoPopValid(fifoPopValid), .txBusy_ff(txBusy_ff), .txObject_ff(txObject_ff),
    .queueFull_ff(queueFull_ff));

// file: tb/msg_sender.sv
module msg_sender (
    input  wire logic clk_sys,   // clock
    input  wire logic rst_n,     // sync reset
    input  wire logic txBusy,    // frame on the wire
    input  wire logic slow,      // long frame
    output logic      msgSent_ff // one-cycle success
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] frameCnt_ff;
    // pulse once per frame, then wait for busy to fall
    always @(posedge clk_sys)
    begin
        if (!rst_n || !txBusy || msgSent_ff)
        begin
            frameCnt_ff <= 5'h00;
            msgSent_ff  <= 1'b0;
        end
        else
        begin
            frameCnt_ff <= frameCnt_ff + 5'h01;
            msgSent_ff  <= frameCnt_ff == (slow ? 5'h14 : 5'h02);
        end
    end
endmodule // msg_sender

// file: tb/tb.sv
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, regWr, regRd, msgSent, fifoPushValid, fifoPopValid;
    logic txBusy_ff, queueFull_ff, slow;
    logic [3:0] regAddr;
    logic [15:0] regWrData, regRdData_ff;
    logic [2:0] fifoPush, fifoPop, txObject_ff;
    int miscompares, compares;
    can_tx_request_and_fifo_pointer can_tx_request_and_fifo_pointer_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData_ff), .msgSent(msgSent),
        .fifoPush(fifoPush), .fifoPushValid(fifoPushValid), .fifoPop(fifoPop),
        .fifoPopValid(fifoPopValid), .txBusy_ff(txBusy_ff), .txObject_ff(txObject_ff),
        .queueFull_ff(queueFull_ff));
    msg_sender msg_sender_i (.clk_sys(clk_sys), .rst_n(rst_n), .txBusy(txBusy_ff),
        .slow(slow), .msgSent_ff(msgSent));
    always #12.5 clk_sys = ~clk_sys;
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        `CHECK(regRdData_ff, e)
    endtask
    // one slot event on a fifo: push moves head, pop moves tail
    task automatic ev(input logic [2:0] i, input logic p);
        @(posedge clk_sys);
        fifoPush <= i;
        fifoPop <= i;
        fifoPushValid <= p;
        fifoPopValid <= !p;
        @(posedge clk_sys);
        fifoPushValid <= 1'b0;
        fifoPopValid <= 1'b0;
    endtask
    task automatic waitBusy(input logic v);
        int n;
        n = 0;
        while (txBusy_ff !== v && n < 60)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        `CHECK(txBusy_ff, v)
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        final_report;
    end
    initial
    begin
        {clk_sys, rst_n, regWr, regRd, fifoPushValid, fifoPopValid} = 6'h00;
        {regAddr, regWrData, fifoPush, fifoPop} = 26'h0;
        slow = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdchk(4'h0, 16'h0000);
        rdchk(4'h7, 16'h0001);
        rdchk(4'h6, 16'h0000);
        rdchk(4'h9, 16'h0000);
        $display("test reset done");
        wr(4'h7, 16'h0000);
        wr(4'h2, 16'h0005);
        rdchk(4'h2, 16'h0004);
        wr(4'h0, 16'hff06);
        rdchk(4'h0, 16'h0004);
        waitBusy(1'b1);
        `CHECK(txObject_ff, 3'h2)
        wr(4'h0, 16'h0000);
        rdchk(4'h0, 16'h0004);
        waitBusy(1'b0);
        rdchk(4'h0, 16'h0000);
        $display("test object done");
        slow = 1'b0;
        wr(4'h0, 16'h0001);
        waitBusy(1'b1);
        `CHECK(txObject_ff, 3'h0)
        waitBusy(1'b0);
        wr(4'h0, 16'h0005);
        waitBusy(1'b1);
        `CHECK(txObject_ff, 3'h0)
        waitBusy(1'b0);
        waitBusy(1'b1);
        `CHECK(txObject_ff, 3'h2)
        waitBusy(1'b0);
        repeat (10) @(posedge clk_sys);
        rdchk(4'h0, 16'h0000);
        wr(4'h1, 16'hffff);
        rdchk(4'h1, 16'h0000);
        $display("test queue done");
        wr(4'h2, 16'h0088);
        wr(4'h3, 16'h0003);
        ev(3'h3, 1'b1);
        ev(3'h3, 1'b1);
        ev(3'h3, 1'b0);
        ev(3'h7, 1'b1);
        rdchk(4'h4, 16'h0020);
        rdchk(4'h5, 16'h0000);
        wr(4'h2, 16'h0080);
        rdchk(4'h4, 16'h0010);
        wr(4'h3, 16'h0007);
        rdchk(4'h4, 16'h0010);
        $display("test pointer done");
        final_report;
    end
endmodule // tb
